/* File: core/host_command_port.sv */
module host_command_port
  import host_port_pkg::*;
(
  input wire logic clk_sys, // core clock
  input wire logic rst, // synchronous reset
  input wire logic sck_scl_i, // host link clock
  input wire logic si_i, // spi data in, strap at reset
  input wire logic ss_n_i, // spi slave select, strap at reset
  input wire logic so_sda_i, // level seen on shared data pin
  output logic so_sda_o, // shared data pin value
  output logic so_sda_oe_n, // low while driving shared data pin
  input wire logic front_channel_data_out_i, // link mode strap
  input wire logic ext_irq_i, // external interrupt request
  input wire logic vector_block_select_i, // vector block placement
  input wire logic bypass_i, // pll bypass request
  input wire logic mute_in_or_spare_pin_five_i, // pin level
  output logic mute_in_or_spare_pin_five_o, // pin value
  output logic mute_in_or_spare_pin_five_oe_n, // low drives
  input wire logic fault_out_or_spare_pin_one_i, // pin level
  output logic fault_out_or_spare_pin_one_o, // pin value
  output logic fault_out_or_spare_pin_one_oe_n, // low drives
  input wire logic data_request_or_spare_pin_zero_i, // pin level
  output logic data_request_or_spare_pin_zero_o, // pin value
  output logic data_request_or_spare_pin_zero_oe_n, // low drives
  input wire logic [2:0] spare_pin_hi_i, // pins four..two level
  output logic [2:0] spare_pin_hi_o, // pins four..two value
  output logic [2:0] spare_pin_hi_oe_n, // low drives
  input pin_cfg_t pin_cfg_i, // core pin programming
  input wire logic [7:0] reply_data_i, // core reply for reads
  output host_cmd_t cmd_o, // decoded word to the core
  output logic [5:0] spare_in_o, // synchronised pin levels
  output logic mute_o, // mute request
  output logic core_irq_o, // interrupt to core
  output logic vector_sel_o, // vector block placement
  output logic pll_bypass_o, // select crystal as core clock
  output logic core_half_clock_out, // core clock divided by two
  output logic spi_mode_o, // strapped link mode
  output logic [6:0] twowire_slave_address // strapped address
);

  typedef enum logic [5:0]
  {
    TW_IDLE = 6'b000001,
    TW_ADDR = 6'b000010,
    TW_ACK = 6'b000100,
    TW_WRITE = 6'b001000,
    TW_READ = 6'b010000,
    TW_RACK = 6'b100000
  } tw_state_t;

  logic [SYNC_W-1:0] raw_s, syn_s;
  logic sck_s, si_s, ss_n_s, sda_s, strap_s;
  logic sck_prev_q, sda_prev_q;
  logic sck_rise, sck_fall, tw_start, tw_stop;

  assign raw_s = {spare_pin_hi_i, mute_in_or_spare_pin_five_i,
    fault_out_or_spare_pin_one_i, data_request_or_spare_pin_zero_i,
    bypass_i, vector_block_select_i, ext_irq_i, front_channel_data_out_i,
    so_sda_i, ss_n_i, si_i, sck_scl_i};

  sync_pair #(.W(SYNC_W)) u_sync
  (
    .clk_sys(clk_sys),
    .async_in(raw_s),
    .sync_out(syn_s)
  );

  assign sck_s = syn_s[0];
  assign si_s = syn_s[1];
  assign ss_n_s = syn_s[2];
  assign sda_s = syn_s[3];
  assign strap_s = syn_s[4];
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;
  assign tw_start = sck_s & sda_prev_q & ~sda_s;
  assign tw_stop = sck_s & ~sda_prev_q & sda_s;

  // ---- straps, pins and clock output ----
  logic spi_mode_q, spi_mode_d;
  logic [6:0] addr_q, addr_d;
  logic [5:0] pin_o_q, pin_o_d, pin_oe_n_q, pin_oe_n_d;
  logic half_q;
  logic sda_o_d, sda_oe_n_d;
  logic [7:0] spi_tx_q;
  logic tw_pull_q;
  logic [5:0] spare_in_d;

  always_comb
  begin
    spi_mode_d = spi_mode_q;
    addr_d = addr_q;
    // straps follow the pins while reset is held, then freeze
    if (rst)
    begin
      spi_mode_d = strap_s;
      addr_d = TW_ADDR_FIXED;
      addr_d[TW_ADDR_SI_BIT] = si_s;
      addr_d[TW_ADDR_SS_BIT] = ss_n_s;
    end
    for (int i = 0; i < 6; i++)
    begin
      pin_o_d[i] = pin_cfg_i.spare_val[i];
      pin_oe_n_d[i] = ~(pin_cfg_i.spare_en[i] & pin_cfg_i.spare_oe[i]);
    end
    if (!pin_cfg_i.spare_en[0])
    begin
      pin_o_d[0] = pin_cfg_i.data_req;
      pin_oe_n_d[0] = 1'b0;
    end
    if (!pin_cfg_i.spare_en[1])
    begin
      pin_o_d[1] = pin_cfg_i.fault;
      pin_oe_n_d[1] = 1'b0;
    end
    spare_in_d = {syn_s[10], syn_s[13:11], syn_s[9], syn_s[8]};
    // spi drives only while selected; two-wire is open drain
    if (spi_mode_q)
    begin
      sda_o_d = spi_tx_q[7];
      sda_oe_n_d = ss_n_s;
    end
    else
    begin
      sda_o_d = 1'b0;
      sda_oe_n_d = ~tw_pull_q;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    spi_mode_q <= spi_mode_d;
    addr_q <= addr_d;
    if (rst)
    begin
      pin_o_q <= '0;
      pin_oe_n_q <= '1;
      half_q <= 1'b0;
      so_sda_o <= 1'b0;
      so_sda_oe_n <= 1'b1;
      spare_in_o <= '0;
      mute_o <= 1'b0;
      core_irq_o <= 1'b0;
      vector_sel_o <= 1'b0;
      pll_bypass_o <= 1'b0;
    end
    else
    begin
      pin_o_q <= pin_o_d;
      pin_oe_n_q <= pin_oe_n_d;
      half_q <= ~half_q;
      so_sda_o <= sda_o_d;
      so_sda_oe_n <= sda_oe_n_d;
      spare_in_o <= spare_in_d;
      mute_o <= ~pin_cfg_i.spare_en[5] & syn_s[10];
      core_irq_o <= syn_s[5];
      vector_sel_o <= syn_s[6];
      // the clock switch itself sits in the clock unit
      pll_bypass_o <= syn_s[7];
    end
  end

  assign data_request_or_spare_pin_zero_o = pin_o_q[0];
  assign data_request_or_spare_pin_zero_oe_n = pin_oe_n_q[0];
  assign fault_out_or_spare_pin_one_o = pin_o_q[1];
  assign fault_out_or_spare_pin_one_oe_n = pin_oe_n_q[1];
  assign spare_pin_hi_o = pin_o_q[4:2];
  assign spare_pin_hi_oe_n = pin_oe_n_q[4:2];
  assign mute_in_or_spare_pin_five_o = pin_o_q[5];
  assign mute_in_or_spare_pin_five_oe_n = pin_oe_n_q[5];
  assign core_half_clock_out = half_q;
  assign spi_mode_o = spi_mode_q;
  assign twowire_slave_address = addr_q;

  // ---- command interpreter, shared by both links ----
  logic word_stb;
  logic [7:0] word_in;
  logic [7:0] left_q, left_d;
  logic [7:0] resp_q, resp_d;
  host_cmd_t cmd_d;
  op_info_t info;

  always_comb
  begin
    info = op_lookup(word_in);
    left_d = left_q;
    resp_d = resp_q;
    cmd_d = '{valid: 1'b0, is_param: 1'b0, kind: CT_NONE, data: word_in};
    if (word_stb)
    begin
      cmd_d.valid = 1'b1;
      resp_d = RESP_IDLE;
      if (left_q != '0)
      begin
        left_d = left_q - 8'h01;
        cmd_d.is_param = 1'b1;
        resp_d[ST_PARAM] = 1'b1;
        resp_d[ST_OK] = 1'b1;
        resp_d[7:RESP_EXP_LSB] = left_d[3:0];
      end
      else if (info.kind == CT_READ)
      begin
        cmd_d.kind = CT_READ;
        resp_d = reply_data_i;
      end
      else
      begin
        cmd_d.kind = info.kind;
        left_d = info.params;
        resp_d[ST_UNKNOWN] = ~info.known;
        resp_d[ST_OK] = info.known;
        resp_d[7:RESP_EXP_LSB] = info.params[3:0];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      left_q <= '0;
      resp_q <= RESP_IDLE;
      cmd_o <= '{valid: 1'b0, is_param: 1'b0, kind: CT_NONE, data: '0};
    end
    else
    begin
      left_q <= left_d;
      resp_q <= resp_d;
      cmd_o <= cmd_d;
    end
  end

  // ---- spi slave, mode 0, msb first ----
  logic [2:0] spi_cnt_q, spi_cnt_d;
  logic [6:0] spi_rx_q, spi_rx_d;
  logic [7:0] spi_tx_d, spi_pipe_q, spi_pipe_d;
  logic spi_stb;
  logic [7:0] spi_word;

  always_comb
  begin
    spi_cnt_d = spi_cnt_q;
    spi_rx_d = spi_rx_q;
    spi_tx_d = spi_tx_q;
    spi_pipe_d = spi_pipe_q;
    spi_stb = 1'b0;
    spi_word = {spi_rx_q, si_s};
    if (!spi_mode_q || ss_n_s)
      spi_cnt_d = '0;
    else if (sck_rise)
    begin
      spi_rx_d = spi_word[6:0];
      spi_cnt_d = spi_cnt_q + 3'd1;
      if (spi_cnt_q == BIT_LAST[2:0])
      begin
        spi_stb = 1'b1;
        // one stage plus the shifter gives a two-word lag
        spi_tx_d = spi_pipe_q;
        spi_pipe_d = resp_d;
      end
    end
    else if (sck_fall && spi_cnt_q != '0)
      spi_tx_d = {spi_tx_q[6:0], 1'b0};
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      spi_cnt_q <= '0;
      spi_rx_q <= '0;
      spi_tx_q <= RESP_IDLE;
      spi_pipe_q <= RESP_IDLE;
      // follow the live levels so release shows no false edge
      sck_prev_q <= sck_s;
      sda_prev_q <= sda_s;
    end
    else
    begin
      spi_cnt_q <= spi_cnt_d;
      spi_rx_q <= spi_rx_d;
      spi_tx_q <= spi_tx_d;
      spi_pipe_q <= spi_pipe_d;
      sck_prev_q <= sck_s;
      sda_prev_q <= sda_s;
    end
  end

  // ---- two-wire slave, half duplex ----
  tw_state_t tw_q, tw_d;
  logic [3:0] tw_cnt_q, tw_cnt_d;
  logic [7:0] tw_sh_q, tw_sh_d;
  logic tw_rd_q, tw_rd_d, tw_ackon_q, tw_ackon_d, tw_pull_d;
  logic tw_stb;
  logic [7:0] tw_byte;

  always_comb
  begin
    tw_d = tw_q;
    tw_cnt_d = tw_cnt_q;
    tw_sh_d = tw_sh_q;
    tw_rd_d = tw_rd_q;
    tw_ackon_d = tw_ackon_q;
    tw_pull_d = tw_pull_q;
    tw_stb = 1'b0;
    tw_byte = {tw_sh_q[6:0], sda_s};
    if (spi_mode_q || tw_stop)
    begin
      tw_d = TW_IDLE;
      tw_pull_d = 1'b0;
    end
    else if (tw_start)
    begin
      tw_d = TW_ADDR;
      tw_cnt_d = '0;
      tw_pull_d = 1'b0;
    end
    else
    begin
      unique case (tw_q)
        TW_IDLE: ;
        TW_ADDR, TW_WRITE:
          if (sck_rise)
          begin
            tw_sh_d = tw_byte;
            tw_cnt_d = tw_cnt_q + 4'd1;
            if (tw_cnt_q == BIT_LAST)
            begin
              tw_cnt_d = '0;
              tw_ackon_d = 1'b0;
              tw_d = TW_ACK;
              if (tw_q == TW_WRITE)
                tw_stb = 1'b1;
              else if (tw_byte[7:1] == addr_q)
                tw_rd_d = tw_byte[0];
              else
                tw_d = TW_IDLE;
            end
          end
        TW_ACK:
          if (sck_fall)
          begin
            tw_ackon_d = ~tw_ackon_q;
            tw_pull_d = ~tw_ackon_q;
            if (tw_ackon_q)
            begin
              tw_d = tw_rd_q ? TW_READ : TW_WRITE;
              // no lag here: the latest response is returned
              tw_sh_d = resp_q;
              tw_pull_d = tw_rd_q & ~resp_q[7];
            end
          end
        TW_READ:
          if (sck_fall)
          begin
            tw_cnt_d = tw_cnt_q + 4'd1;
            tw_sh_d = {tw_sh_q[6:0], 1'b0};
            tw_pull_d = ~tw_sh_q[6];
            if (tw_cnt_q == BIT_LAST)
            begin
              tw_pull_d = 1'b0;
              tw_ackon_d = 1'b0;
              tw_d = TW_RACK;
            end
          end
        TW_RACK:
          if (sck_rise)
          begin
            tw_ackon_d = ~sda_s;
            if (sda_s)
              tw_d = TW_IDLE;
          end
          else if (sck_fall && tw_ackon_q)
          begin
            tw_cnt_d = '0;
            tw_sh_d = resp_q;
            tw_pull_d = ~resp_q[7];
            tw_d = TW_READ;
          end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tw_q <= TW_IDLE;
      tw_cnt_q <= '0;
      tw_sh_q <= '0;
      tw_rd_q <= 1'b0;
      tw_ackon_q <= 1'b0;
      tw_pull_q <= 1'b0;
    end
    else
    begin
      tw_q <= tw_d;
      tw_cnt_q <= tw_cnt_d;
      tw_sh_q <= tw_sh_d;
      tw_rd_q <= tw_rd_d;
      tw_ackon_q <= tw_ackon_d;
      tw_pull_q <= tw_pull_d;
    end
  end

  assign word_stb = spi_stb | tw_stb;
  assign word_in = spi_mode_q ? spi_word : tw_byte;

endmodule

/* File: inc/host_port_pkg.sv */
package host_port_pkg;

  localparam int WORD_W = 8;
  localparam int SYNC_W = 14;

  // opcodes of the write class; the read class is a single code
  localparam logic [7:0] OP_READ = 8'h00;
  localparam logic [7:0] OP_SEL_SURROUND = 8'h85;
  localparam logic [7:0] OP_SEL_PCM = 8'h86;
  localparam logic [7:0] OP_SEL_MPEG = 8'h87;
  localparam logic [7:0] OP_SEL_NOISE = 8'h83;
  localparam logic [7:0] OP_SEL_USER = 8'h88;
  localparam logic [7:0] OP_RUN = 8'h8A;
  localparam logic [7:0] OP_MUTE = 8'h8B;
  localparam logic [7:0] OP_UNMUTE = 8'h89;
  localparam logic [7:0] OP_HALT = 8'h8C;
  localparam logic [7:0] OP_HALT_FLUSH = 8'h8D;
  localparam logic [7:0] OP_STATUS = 8'h8E;
  localparam logic [7:0] OP_RX_STATUS = 8'h8F;
  localparam logic [7:0] OP_GET_TIME = 8'h9A;
  localparam logic [7:0] OP_NOOP = 8'h80;
  localparam logic [7:0] OP_PLL_TABLE = 8'h98;
  localparam logic [7:0] OP_PLL_CONFIG = 8'h99;
  localparam logic [7:0] OP_CONFIG = 8'h82;
  localparam logic [7:0] OP_SET_TIME = 8'h97;
  localparam logic [7:0] OP_VERSION = 8'h81;
  localparam logic [7:0] OP_LOADER = 8'h90;
  localparam logic [7:0] OP_TX_STATUS = 8'h95;
  localparam logic [7:0] OP_PARAMS = 8'h96;
  localparam logic [7:0] OP_EXEC = 8'h91;
  localparam logic [7:0] OP_SPARE_IO = 8'h92;
  localparam logic [7:0] OP_MEM_WRITE = 8'h93;
  localparam logic [7:0] OP_MEM_READ = 8'h94;

  // parameter word counts
  localparam logic [7:0] NP_0 = 8'h00;
  localparam logic [7:0] NP_1 = 8'h01;
  localparam logic [7:0] NP_4 = 8'h04;
  localparam logic [7:0] NP_6 = 8'h06;
  localparam logic [7:0] NP_7 = 8'h07;
  localparam logic [7:0] NP_8 = 8'h08;

  // response word: expected words high nibble, status low nibble
  localparam int RESP_EXP_LSB = 4;
  localparam int ST_UNKNOWN = 0;
  localparam int ST_PARAM = 1;
  localparam int ST_READ = 2;
  localparam int ST_OK = 3;
  localparam logic [7:0] RESP_IDLE = 8'h00;

  // two-wire address bits that are not strapped from host pins
  localparam logic [6:0] TW_ADDR_FIXED = 7'h40;
  localparam int TW_ADDR_SI_BIT = 5;
  localparam int TW_ADDR_SS_BIT = 4;
  localparam logic [3:0] BIT_LAST = 4'h7;

  typedef enum logic [4:0]
  {
    CT_NONE = 5'b00001,
    CT_PRIMARY = 5'b00010,
    CT_OPERATE = 5'b00100,
    CT_SETUP = 5'b01000,
    CT_READ = 5'b10000
  } cmd_type_t;

  typedef struct packed
  {
    logic known;
    cmd_type_t kind;
    logic [7:0] params;
  } op_info_t;

  typedef struct packed
  {
    logic valid;
    logic is_param;
    cmd_type_t kind;
    logic [WORD_W-1:0] data;
  } host_cmd_t;

  typedef struct packed
  {
    logic [5:0] spare_en;
    logic [5:0] spare_oe;
    logic [5:0] spare_val;
    logic fault;
    logic data_req;
  } pin_cfg_t;

  function automatic op_info_t op_lookup(input logic [7:0] op);
    op_info_t r;
    r = '{known: 1'b1, kind: CT_SETUP, params: NP_0};
    case (op)
      OP_READ: r.kind = CT_READ;
      OP_SEL_SURROUND, OP_SEL_PCM, OP_SEL_MPEG, OP_SEL_NOISE, OP_SEL_USER:
        r = '{known: 1'b1, kind: CT_PRIMARY, params: NP_8};
      OP_RUN, OP_MUTE, OP_UNMUTE, OP_HALT, OP_HALT_FLUSH, OP_STATUS,
      OP_RX_STATUS, OP_GET_TIME, OP_NOOP:
        r.kind = CT_OPERATE;
      OP_PLL_TABLE: r.params = NP_6;
      OP_PLL_CONFIG, OP_LOADER, OP_PARAMS: r.params = NP_1;
      OP_CONFIG: r.params = NP_8;
      OP_SET_TIME, OP_MEM_WRITE, OP_MEM_READ: r.params = NP_7;
      OP_VERSION: r.params = NP_0;
      OP_TX_STATUS, OP_EXEC, OP_SPARE_IO: r.params = NP_4;
      default: r = '{known: 1'b0, kind: CT_NONE, params: NP_0};
    endcase
    return r;
  endfunction

endpackage

/* File: core/sync_pair.sv */
module sync_pair
  import host_port_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic clk_sys, // sampling clock
  input wire logic [W-1:0] async_in, // levels from other domains
  output logic [W-1:0] sync_out // two-flop synchronised levels
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  // no reset: straps must see live pin levels while reset is held
  always_ff @(posedge clk_sys)
  begin
    meta_q <= async_in;
    sync_out <= meta_q;
  end

endmodule

/* File: dv/host_command_port_props.sv */
module host_port_checker
  import host_port_pkg::*;
(
  input wire logic clk_sys, // core clock
  input wire logic rst, // sync reset
  input wire logic ss_n_i, // select
  input wire logic so_sda_o, // data pin
  input wire logic so_sda_oe_n, // data enable
  input wire logic ext_irq_i, // irq pin
  input wire logic vector_block_select_i, // map pin
  input wire logic bypass_i, // bypass pin
  input wire logic mute_in_or_spare_pin_five_o, // pin 5
  input wire logic mute_in_or_spare_pin_five_oe_n, // pin 5
  input wire logic fault_out_or_spare_pin_one_o, // pin 1
  input wire logic fault_out_or_spare_pin_one_oe_n, // pin 1
  input wire logic data_request_or_spare_pin_zero_o, // pin 0
  input wire logic data_request_or_spare_pin_zero_oe_n, // pin 0
  input wire logic [2:0] spare_pin_hi_o, // pins 4..2
  input wire logic [2:0] spare_pin_hi_oe_n, // pins 4..2
  input pin_cfg_t pin_cfg_i, // pin setup
  input host_cmd_t cmd_o, // decoded word
  input wire logic core_irq_o, // irq out
  input wire logic vector_sel_o, // map out
  input wire logic pll_bypass_o, // bypass out
  input wire logic core_half_clock_out, // half clock
  input wire logic spi_mode_o, // link mode
  input wire logic [6:0] twowire_slave_address // address
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic [5:0] pin_oe_n, pin_o, drv, want;
  assign pin_oe_n = {mute_in_or_spare_pin_five_oe_n, spare_pin_hi_oe_n,
    fault_out_or_spare_pin_one_oe_n, data_request_or_spare_pin_zero_oe_n};
  assign pin_o = {mute_in_or_spare_pin_five_o, spare_pin_hi_o,
    fault_out_or_spare_pin_one_o, data_request_or_spare_pin_zero_o};
  // pins 1 and 0 carry their function outputs unless made spare
  assign drv = (~pin_cfg_i.spare_en & 6'h03) |
    (pin_cfg_i.spare_en & pin_cfg_i.spare_oe);
  assign want = (pin_cfg_i.spare_en & pin_cfg_i.spare_val) |
    (~pin_cfg_i.spare_en & {4'h0, pin_cfg_i.fault, pin_cfg_i.data_req});

  sequence cfg_held;
    !$past(rst) && $stable(pin_cfg_i);
  endsequence

  AST_HALF_CLOCK: assert property (!$past(rst) |->
    core_half_clock_out != $past(core_half_clock_out))
    else $error("half clock stalled");
  AST_IRQ_PASS: assert property ($stable(ext_irq_i) [*6] |->
    core_irq_o == ext_irq_i) else $error("irq not passed");
  AST_VECTOR_PASS: assert property (
    $stable(vector_block_select_i) [*6] |->
    vector_sel_o == vector_block_select_i) else $error("map not passed");
  AST_BYPASS_PASS: assert property ($stable(bypass_i) [*6] |->
    pll_bypass_o == bypass_i) else $error("bypass not passed");
  AST_PIN_DRIVE: assert property (cfg_held |->
    pin_oe_n == ~drv) else $error("pin enable wrong");
  AST_PIN_VALUE: assert property (cfg_held |->
    ((pin_o ^ want) & drv) == 6'h00) else $error("pin value wrong");
  AST_SPI_DRIVE: assert property ((spi_mode_o && !ss_n_i) [*5] |->
    !so_sda_oe_n) else $error("spi output not driven");
  AST_SPI_RELEASE: assert property ((spi_mode_o && ss_n_i) [*5] |->
    so_sda_oe_n) else $error("spi output not released");
  AST_OPEN_DRAIN: assert property (!spi_mode_o && !so_sda_oe_n |->
    !so_sda_o) else $error("two-wire pin driven high");
  AST_ONE_PULSE: assert property (cmd_o.valid |=> !cmd_o.valid)
    else $error("word strobe too long");
  AST_STRAP_HELD: assert property (
    !$past(rst) && !$past(rst, 2) |->
    $stable(twowire_slave_address) && $stable(spi_mode_o))
    else $error("strap changed");
  AST_ADDR_FIXED: assert property (!$past(rst) |->
    (twowire_slave_address & 7'h4F) == TW_ADDR_FIXED)
    else $error("fixed address bits wrong");

  cover property (cmd_o.valid && cmd_o.is_param);
  cover property (cmd_o.valid && cmd_o.kind == CT_PRIMARY);
  cover property (!spi_mode_o && !so_sda_oe_n);
endmodule

bind host_command_port host_port_checker chk (
  .clk_sys, .rst, .ss_n_i, .so_sda_o, .so_sda_oe_n, .ext_irq_i,
  .vector_block_select_i, .bypass_i, .mute_in_or_spare_pin_five_o,
  .mute_in_or_spare_pin_five_oe_n, .fault_out_or_spare_pin_one_o,
  .fault_out_or_spare_pin_one_oe_n, .data_request_or_spare_pin_zero_o,
  .data_request_or_spare_pin_zero_oe_n, .spare_pin_hi_o,
  .spare_pin_hi_oe_n, .pin_cfg_i, .cmd_o, .core_irq_o, .vector_sel_o,
  .pll_bypass_o, .core_half_clock_out, .spi_mode_o, .twowire_slave_address
);

/* File: dv/host_link_model.sv */
module host_link_model
(
  input wire logic sda, // resolved data wire
  output logic sck, // link clock
  output logic si, // spi data out
  output logic ss_n, // spi select
  output logic pull // pulls data wire low
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sck = 1'b0;
    si = 1'b0;
    ss_n = 1'b1;
    pull = 1'b0;
  end

  task set_pins(input logic s, input logic n);
    si <= s;
    ss_n <= n;
  endtask

  // mode 0: clock idles low, bit sampled on the rise
  task spi_word(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      si = tx[i];
      #40;
      sck = 1'b1;
      rx[i] = sda;
      #40;
      sck = 1'b0;
    end
  endtask

  task tw_bit(input logic b, output logic r);
    pull = !b;
    #20;
    sck = 1'b1;
    #20;
    r = sda;
    #20;
    sck = 1'b0;
    #20;
  endtask

  task tw_start;
    sck = 1'b1;
    pull = 1'b0;
    #40;
    pull = 1'b1;
    #40;
    sck = 1'b0;
    #20;
  endtask

  task tw_stop;
    pull = 1'b1;
    #40;
    sck = 1'b1;
    #40;
    pull = 1'b0;
    #40;
  endtask

  task tw_byte(input logic [7:0] tx, input logic ack_in,
    output logic [7:0] rx, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      tw_bit(tx[i], b);
      rx[i] = b;
    end
    tw_bit(ack_in, ack);
  endtask
endmodule

/* File: dv/host_command_port_test.sv */
module host_command_port_test
  import host_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys, rst, sck_scl_i, si_i, ss_n_i, so_sda_i, so_sda_o;
  logic so_sda_oe_n, front_channel_data_out_i, ext_irq_i, pull;
  logic vector_block_select_i, bypass_i, mute_o, core_irq_o;
  logic vector_sel_o, pll_bypass_o, core_half_clock_out, spi_mode_o;
  logic [5:0] pin_ext, pin_lvl, spare_in_o;
  wire logic [5:0] pin_o, pin_oe_n;
  logic [6:0] twowire_slave_address;
  logic [7:0] reply_data_i;
  pin_cfg_t pin_cfg_i;
  host_cmd_t cmd_o;
  host_cmd_t seen[$];
  host_cmd_t xq[$];
  int error_cnt, cmp_count, rem;

  // the data wire has a pull-up: released means high
  assign pin_lvl = (pin_oe_n & pin_ext) | (~pin_oe_n & pin_o);
  assign so_sda_i = !pull & (so_sda_oe_n | so_sda_o);

  host_link_model host (.sda(so_sda_i), .sck(sck_scl_i), .si(si_i),
    .ss_n(ss_n_i), .pull(pull));

  host_command_port dut (
    .clk_sys, .rst, .sck_scl_i, .si_i, .ss_n_i, .so_sda_i, .so_sda_o,
    .so_sda_oe_n, .front_channel_data_out_i, .ext_irq_i,
    .vector_block_select_i, .bypass_i, .pin_cfg_i, .reply_data_i, .cmd_o,
    .spare_in_o, .mute_o, .core_irq_o, .vector_sel_o, .pll_bypass_o,
    .core_half_clock_out, .spi_mode_o, .twowire_slave_address,
    .mute_in_or_spare_pin_five_i(pin_lvl[5]),
    .mute_in_or_spare_pin_five_o(pin_o[5]),
    .mute_in_or_spare_pin_five_oe_n(pin_oe_n[5]),
    .spare_pin_hi_i(pin_lvl[4:2]),
    .spare_pin_hi_o(pin_o[4:2]),
    .spare_pin_hi_oe_n(pin_oe_n[4:2]),
    .fault_out_or_spare_pin_one_i(pin_lvl[1]),
    .fault_out_or_spare_pin_one_o(pin_o[1]),
    .fault_out_or_spare_pin_one_oe_n(pin_oe_n[1]),
    .data_request_or_spare_pin_zero_i(pin_lvl[0]),
    .data_request_or_spare_pin_zero_o(pin_o[0]),
    .data_request_or_spare_pin_zero_oe_n(pin_oe_n[0])
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
    if (cmd_o.valid === 1'b1)
      seen.push_back(cmd_o);

  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic cmd_type_t kind_of(input logic [7:0] op);
    case (op)
      OP_READ: return CT_READ;
      OP_STATUS: return CT_OPERATE;
      OP_SEL_SURROUND: return CT_PRIMARY;
      OP_SPARE_IO: return CT_SETUP;
      default: return CT_NONE;
    endcase
  endfunction

  // logs the expected strobe, returns the expected response byte
  function automatic logic [7:0] note(input logic [7:0] w);
    cmd_type_t k;
    k = kind_of(w);
    xq.push_back('{valid: 1'b1, is_param: rem > 0, kind: k, data: w});
    if (rem > 0)
    begin
      rem--;
      return {rem[3:0], 4'h0} | 8'(1 << ST_PARAM) | 8'(1 << ST_OK);
    end
    rem = (k == CT_PRIMARY) ? 8 : (k == CT_SETUP) ? 4 : 0;
    if (k == CT_READ)
      return reply_data_i;
    if (k == CT_NONE)
      return 8'(1 << ST_UNKNOWN);
    return {rem[3:0], 4'h0} | 8'(1 << ST_OK);
  endfunction

  task automatic check_cmds;
    check("word count", 8'(xq.size()), 8'(seen.size()));
    foreach (xq[i])
    begin
      check("cmd data", xq[i].data, seen[i].data);
      check("cmd param", 8'(xq[i].is_param), 8'(seen[i].is_param));
      if (!xq[i].is_param)
        check("cmd kind", 8'(xq[i].kind), 8'(seen[i].kind));
    end
  endtask

  task automatic do_reset(input logic fc, input logic s_si, input logic s_ss);
    @(posedge clk_sys);
    rst <= 1'b1;
    front_channel_data_out_i <= fc;
    host.set_pins(s_si, s_ss);
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    host.set_pins(1'b0, 1'b1);
    repeat (4) @(posedge clk_sys);
    #1;
    rem = 0;
    xq.delete();
    seen.delete();
  endtask

  task automatic spi_test;
    logic [7:0] words[$];
    logic [7:0] exp[$];
    logic [7:0] rx;
    do_reset(1'b1, 1'b0, 1'b1);
    check("spi mode", 8'h01, 8'(spi_mode_o));
    check("spi address", 8'h50, 8'(twowire_slave_address));
    words = '{OP_STATUS, OP_SPARE_IO, 8'h11, 8'h22, 8'h33, 8'h44, OP_READ,
      8'hFF, OP_SEL_SURROUND};
    // parameters that look like opcodes must still count as parameters
    for (int i = 0; i < 8; i++)
      words.push_back(8'h88 + 8'(i));
    words = {words, OP_READ, OP_READ, OP_READ};
    host.set_pins(1'b0, 1'b0);
    #80;
    foreach (words[i])
    begin
      host.spi_word(words[i], rx);
      exp.push_back(note(words[i]));
      check("spi reply", (i > 1) ? exp[i - 2] : RESP_IDLE, rx);
    end
    host.set_pins(1'b0, 1'b1);
    repeat (10) @(posedge clk_sys);
    check_cmds;
    $display("spi test done");
  endtask

  task automatic tw_cmd(input logic [7:0] op);
    logic [7:0] rx, exp;
    logic [6:0] adr;
    logic ack;
    adr = TW_ADDR_FIXED | 7'h20;
    exp = note(op);
    host.tw_start();
    host.tw_byte({adr, 1'b0}, 1'b1, rx, ack);
    check("address ack", 8'h00, 8'(ack));
    host.tw_byte(op, 1'b1, rx, ack);
    check("data ack", 8'h00, 8'(ack));
    host.tw_stop();
    host.tw_start();
    host.tw_byte({adr, 1'b1}, 1'b1, rx, ack);
    host.tw_byte(8'hFF, 1'b0, rx, ack);
    check("tw reply", exp, rx);
    host.tw_byte(8'hFF, 1'b1, rx, ack);
    check("tw reply again", exp, rx);
    host.tw_stop();
  endtask

  task automatic tw_test;
    logic [7:0] rx;
    logic ack;
    do_reset(1'b0, 1'b1, 1'b0);
    check("tw mode", 8'h00, 8'(spi_mode_o));
    check("tw address", 8'h60, 8'(twowire_slave_address));
    host.tw_start();
    host.tw_byte(8'hC2, 1'b1, rx, ack);
    host.tw_stop();
    check("foreign address ack", 8'h01, 8'(ack));
    tw_cmd(OP_STATUS);
    tw_cmd(OP_SPARE_IO);
    tw_cmd(8'h8C);
    check_cmds;
    $display("two-wire test done");
  endtask

  task automatic pin_case(input logic [5:0] en, oe, val, ext,
    input logic f, d, m, input logic [5:0] lvl, oen);
    @(posedge clk_sys);
    pin_cfg_i <= '{spare_en: en, spare_oe: oe, spare_val: val,
      fault: f, data_req: d};
    pin_ext <= ext;
    ext_irq_i <= m;
    vector_block_select_i <= m;
    bypass_i <= m;
    repeat (8) @(posedge clk_sys);
    #1;
    check("pin levels", 8'(lvl), 8'(spare_in_o));
    check("pin enables", 8'(oen), 8'(pin_oe_n));
    check("mute", 8'(!en[5] && ext[5]), 8'(mute_o));
    check("irq", 8'(m), 8'(core_irq_o));
    check("vector", 8'(m), 8'(vector_sel_o));
    check("bypass", 8'(m), 8'(pll_bypass_o));
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    front_channel_data_out_i = 1'b1;
    ext_irq_i = 1'b0;
    vector_block_select_i = 1'b0;
    bypass_i = 1'b0;
    pin_ext = 6'h00;
    pin_cfg_i = '0;
    reply_data_i = 8'h5A;
    error_cnt = 0;
    cmp_count = 0;
    spi_test;
    pin_case(6'h00, 6'h00, 6'h00, 6'h2A, 1'b0, 1'b1, 1'b1, 6'h29, 6'h3C);
    pin_case(6'h3F, 6'h15, 6'h05, 6'h2A, 1'b1, 1'b0, 1'b0, 6'h2F, 6'h2A);
    $display("pin test done");
    tw_test;
    print_verdict;
  end
endmodule
